/* File: rtl/psw_sequencer.sv */
// power-state sequencer driven by the power switch, wake sources and software sleep and soft-off requests
// Contract
// - in soft-off, a short switch press powers the system on
// - in working, a short press enters soft-off or suspend as software configured
// - in working, a long press forces fail-safe power off
// - in sleep, a short press wakes back to working
// - in sleep, a long press powers the system off
// - switch events wake from CPU-stopped, suspend-to-RAM and soft-off
// - RTC alarm and LAN wake from suspend-to-RAM and from soft-off
// - modem and USB wake from CPU-stopped and suspend-to-RAM, ignored in soft-off
// - suspend-to-RAM only allowed when the capable hub strap is set
// - CPU-stopped keeps the processor powered in stop-grant
// - suspend-to-RAM removes processor power but keeps memory powered
// - leaving soft-off always runs a full cold boot reset
// - in suspend-to-RAM only memory and wake logic stay powered, in soft-off only wake logic stays powered
`default_nettype none
`include "psw_defs.svh"
module psw_sequencer
  import psw_pkg::*;
#(
  parameter int unsigned DEB_CYC = `PSW_DEB_MS * `PSW_CLK_KHZ,
  parameter int unsigned HOLD_CYC = `PSW_HOLD_MS * `PSW_CLK_KHZ,
  parameter int unsigned BOOT_CYC = `PSW_BOOT_MS * `PSW_CLK_KHZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pwr_sw_n,
  input wire psw_wake_t i_wake,
  input wire logic i_s3_capable,
  input wire psw_tgt_t i_btn_tgt,
  input wire psw_os_req_t i_os_req,
  output psw_state_t o_state,
  output psw_rails_t o_rails,
  output logic o_cpu_stop,
  output logic o_cold_rst,
  output logic o_wake
);
  psw_state_t st_q;
  psw_state_t st_d;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  psw_wake_t wk;
  logic s3_ok;
  logic sw_short;
  logic sw_long;
  logic [`PSW_CNT_W-1:0] boot_q;

  psw_switch_timer #(
    .DEB_CYC(DEB_CYC),
    .HOLD_CYC(HOLD_CYC)
  ) u_sw (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sw_n(i_pwr_sw_n),
    .o_short(sw_short),
    .o_long(sw_long)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {i_s3_capable, i_wake};
      sync2_q <= sync1_q;
    end
  end
  assign wk = sync2_q[3:0];
  assign s3_ok = sync2_q[4];

  // without the capable hub a suspend-to-RAM request falls back to CPU-stopped
  function automatic psw_state_t tgt_state(input psw_tgt_t tgt, input logic ok);
    psw_state_t s;
    s = PSW_OFF;
    if (tgt == PSW_TGT_S1) s = PSW_S1;
    else if (tgt == PSW_TGT_S3) s = ok ? PSW_S3 : PSW_S1;
    return s;
  endfunction

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      PSW_OFF: begin
        if (sw_short || wk.rtc || wk.lan) st_d = PSW_BOOT;
      end
      PSW_BOOT: begin
        if (boot_q == `PSW_CNT_W'(BOOT_CYC - 1)) st_d = PSW_WORK;
      end
      PSW_WORK: begin
        if (sw_long) st_d = PSW_OFF;
        else if (sw_short) st_d = tgt_state(i_btn_tgt, s3_ok);
        else if (i_os_req.valid) st_d = tgt_state(i_os_req.tgt, s3_ok);
      end
      PSW_S1: begin
        if (sw_long) st_d = PSW_OFF;
        else if (sw_short || wk.modem || wk.usb) st_d = PSW_WORK;
      end
      PSW_S3: begin
        if (sw_long) st_d = PSW_OFF;
        else if (sw_short || wk.rtc || wk.lan || wk.modem || wk.usb) st_d = PSW_WORK;
      end
      default: st_d = PSW_OFF;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) st_q <= PSW_OFF;
    else st_q <= st_d;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || st_q != PSW_BOOT) boot_q <= '0;
    else boot_q <= boot_q + `PSW_CNT_W'(1);
  end

  // outputs follow the next state so they line up with o_state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_state <= PSW_OFF;
      o_rails <= '{main_pwr: 1'h0, cpu_pwr: 1'h0, mem_pwr: 1'h0, dev_pwr: 1'h0, wake_pwr: 1'h1};
      o_cpu_stop <= 1'h0;
      o_cold_rst <= 1'h0;
      o_wake <= 1'h0;
    end else begin
      o_state <= st_d;
      o_rails.main_pwr <= st_d inside {PSW_BOOT, PSW_WORK, PSW_S1};
      o_rails.cpu_pwr <= st_d inside {PSW_BOOT, PSW_WORK, PSW_S1};
      o_rails.mem_pwr <= st_d != PSW_OFF;
      o_rails.dev_pwr <= st_d inside {PSW_BOOT, PSW_WORK, PSW_S1};
      o_rails.wake_pwr <= 1'h1;
      o_cpu_stop <= st_d == PSW_S1;
      o_cold_rst <= st_d == PSW_BOOT;
      o_wake <= (st_q == PSW_OFF && st_d == PSW_BOOT) || (st_q inside {PSW_S1, PSW_S3} && st_d == PSW_WORK);
    end
  end

  property p_off_short_on;
    @(posedge i_clk) disable iff (i_rst) st_q == PSW_OFF && sw_short |=> st_q == PSW_BOOT ##1 o_cold_rst;
  endproperty
  a_off_short_on: assert property (p_off_short_on) else $error("short press in off did not boot");
  property p_work_short;
    @(posedge i_clk) disable iff (i_rst)
      st_q == PSW_WORK && sw_short && !sw_long && i_btn_tgt == PSW_TGT_S5 |=> st_q == PSW_OFF && !o_rails.main_pwr;
  endproperty
  a_work_short: assert property (p_work_short) else $error("short press in working did not soft-off");
  property p_work_long;
    @(posedge i_clk) disable iff (i_rst) st_q == PSW_WORK && sw_long |=> o_state == PSW_OFF && !o_rails.cpu_pwr;
  endproperty
  a_work_long: assert property (p_work_long) else $error("long press in working did not power off");
  property p_sleep_short;
    @(posedge i_clk) disable iff (i_rst) st_q inside {PSW_S1, PSW_S3} && sw_short && !sw_long |=> st_q == PSW_WORK && o_wake;
  endproperty
  a_sleep_short: assert property (p_sleep_short) else $error("short press in sleep did not wake");
  property p_sleep_long;
    @(posedge i_clk) disable iff (i_rst) st_q inside {PSW_S1, PSW_S3} && sw_long |=> st_q == PSW_OFF;
  endproperty
  a_sleep_long: assert property (p_sleep_long) else $error("long press in sleep did not power off");
  property p_short_long_excl;
    @(posedge i_clk) disable iff (i_rst) sw_long |=> !sw_short [*2];
  endproperty
  a_short_long_excl: assert property (p_short_long_excl) else $error("long press also reported short");
  property p_rtc_lan_wake;
    @(posedge i_clk) disable iff (i_rst)
      st_q inside {PSW_S3, PSW_OFF} && (wk.rtc || wk.lan) && !sw_long |=> st_q inside {PSW_WORK, PSW_BOOT};
  endproperty
  a_rtc_lan_wake: assert property (p_rtc_lan_wake) else $error("rtc or lan wake missed");
  property p_modem_usb_off;
    @(posedge i_clk) disable iff (i_rst)
      st_q == PSW_OFF && !sw_short && !wk.rtc && !wk.lan |=> st_q == PSW_OFF;
  endproperty
  a_modem_usb_off: assert property (p_modem_usb_off) else $error("off left without a valid wake");
  property p_s3_strap;
    @(posedge i_clk) disable iff (i_rst) st_q != PSW_S3 && st_d == PSW_S3 |-> s3_ok;
  endproperty
  a_s3_strap: assert property (p_s3_strap) else $error("suspend-to-RAM entered without strap");
  property p_s1_rails;
    @(posedge i_clk) disable iff (i_rst) o_state == PSW_S1 |-> o_cpu_stop && o_rails.cpu_pwr && o_rails.mem_pwr;
  endproperty
  a_s1_rails: assert property (p_s1_rails) else $error("cpu-stopped rails wrong");
  property p_s3_rails;
    @(posedge i_clk) disable iff (i_rst) o_state == PSW_S3 |-> !o_rails.cpu_pwr && o_rails.mem_pwr && !o_cpu_stop;
  endproperty
  a_s3_rails: assert property (p_s3_rails) else $error("suspend-to-RAM rails wrong");
  property p_cold_boot;
    @(posedge i_clk) disable iff (i_rst) $past(o_state) == PSW_OFF && o_state != PSW_OFF |-> o_cold_rst;
  endproperty
  a_cold_boot: assert property (p_cold_boot) else $error("soft-off left without cold reset");
  property p_deep_rails;
    @(posedge i_clk) disable iff (i_rst) o_state inside {PSW_S3, PSW_OFF} |-> !o_rails.dev_pwr && o_rails.wake_pwr;
  endproperty
  a_deep_rails: assert property (p_deep_rails) else $error("device rails on in deep sleep");

  c_boot_done: cover property (@(posedge i_clk) disable iff (i_rst) st_q == PSW_BOOT ##1 st_q == PSW_WORK);
  c_s3_resume: cover property (@(posedge i_clk) disable iff (i_rst) st_q == PSW_S3 ##1 st_q == PSW_WORK);
  c_fail_safe: cover property (@(posedge i_clk) disable iff (i_rst) st_q == PSW_WORK && sw_long);
  c_s1_modem: cover property (@(posedge i_clk) disable iff (i_rst) st_q == PSW_S1 && wk.modem ##1 st_q == PSW_WORK);
endmodule
`default_nettype wire

/* File: pkg/psw_defs.svh */
// timing constants for the power switch and wake sequencer
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH
`define PSW_CLK_KHZ 250000
`define PSW_HOLD_MS 4000
`define PSW_DEB_MS 16
`define PSW_BOOT_MS 10
`define PSW_CNT_W 32
`endif

/* File: pkg/psw_pkg.sv */
// types shared by the power switch and wake sequencer
`default_nettype none
package psw_pkg;
  typedef enum logic [4:0] {
    PSW_OFF  = 5'h01,
    PSW_BOOT = 5'h02,
    PSW_WORK = 5'h04,
    PSW_S1   = 5'h08,
    PSW_S3   = 5'h10
  } psw_state_t;
  typedef enum logic [1:0] {
    PSW_TGT_S5 = 2'h0,
    PSW_TGT_S1 = 2'h1,
    PSW_TGT_S3 = 2'h2
  } psw_tgt_t;
  typedef struct packed {
    logic valid;
    psw_tgt_t tgt;
  } psw_os_req_t;
  typedef struct packed {
    logic rtc;
    logic lan;
    logic modem;
    logic usb;
  } psw_wake_t;
  typedef struct packed {
    logic main_pwr;
    logic cpu_pwr;
    logic mem_pwr;
    logic dev_pwr;
    logic wake_pwr;
  } psw_rails_t;
endpackage
`default_nettype wire

/* File: rtl/psw_switch_timer.sv */
// power switch synchroniser, debouncer and hold timer
`default_nettype none
`include "psw_defs.svh"
module psw_switch_timer #(
  parameter int unsigned DEB_CYC = `PSW_DEB_MS * `PSW_CLK_KHZ,
  parameter int unsigned HOLD_CYC = `PSW_HOLD_MS * `PSW_CLK_KHZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sw_n,
  output logic o_short,
  output logic o_long
);
  logic sync1_q;
  logic sync2_q;
  logic stable_q;
  logic [`PSW_CNT_W-1:0] deb_q;
  logic [`PSW_CNT_W-1:0] hold_q;
  logic long_done_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
    end else begin
      sync1_q <= ~i_sw_n;
      sync2_q <= sync1_q;
    end
  end

  // a level change must hold for the debounce time before it counts
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      deb_q <= '0;
      stable_q <= 1'h0;
    end else if (sync2_q == stable_q) begin
      deb_q <= '0;
    end else if (deb_q == `PSW_CNT_W'(DEB_CYC - 1)) begin
      deb_q <= '0;
      stable_q <= sync2_q;
    end else begin
      deb_q <= deb_q + `PSW_CNT_W'(1);
    end
  end

  // long fires the moment the hold reaches the threshold, so exactly the threshold is long
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold_q <= '0;
      long_done_q <= 1'h0;
      o_short <= 1'h0;
      o_long <= 1'h0;
    end else begin
      o_short <= 1'h0;
      o_long <= 1'h0;
      if (stable_q) begin
        if (!long_done_q) begin
          if (hold_q == `PSW_CNT_W'(HOLD_CYC - 1)) begin
            o_long <= 1'h1;
            long_done_q <= 1'h1;
          end else begin
            hold_q <= hold_q + `PSW_CNT_W'(1);
          end
        end
      end else begin
        hold_q <= '0;
        long_done_q <= 1'h0;
        o_short <= (hold_q != '0) && !long_done_q;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/psw_far_side.sv */
// far-side model: front-panel power switch and wake source pins
`default_nettype none
module psw_far_side
  import psw_pkg::*;
(
  input wire logic i_clk,
  output logic o_sw_n,
  output psw_wake_t o_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sw_n = 1'b1;
    o_wake = '0;
  end
  // switch held low for n cycles, then back to its pull-up level
  task automatic press(input int n);
    @(posedge i_clk);
    o_sw_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_sw_n <= 1'b1;
  endtask
  // wake sources raise their level for a few cycles, then drop it
  task automatic wake_pulse(input psw_wake_t w);
    @(posedge i_clk);
    o_wake <= w;
    repeat (4) @(posedge i_clk);
    o_wake <= '0;
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the power switch and wake sequencer
`default_nettype none
module testbench
  import psw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, sw_n, strap, cpu_stop, cold_rst, wk;
  psw_wake_t wake;
  psw_tgt_t btn_tgt;
  psw_os_req_t os_req;
  psw_state_t st;
  psw_rails_t rails;
  int mismatches = 0;
  int compares = 0;
  int wakes = 0;
  int exp_wakes = 0;
  psw_state_t prev = PSW_OFF;
  logic [31:0] seed = 32'h2D4B;
  psw_sequencer #(.DEB_CYC(4), .HOLD_CYC(20), .BOOT_CYC(8)) psw_sequencer_inst (
    .i_clk(clk), .i_rst(rst), .i_pwr_sw_n(sw_n), .i_wake(wake), .i_s3_capable(strap),
    .i_btn_tgt(btn_tgt), .i_os_req(os_req), .o_state(st), .o_rails(rails),
    .o_cpu_stop(cpu_stop), .o_cold_rst(cold_rst), .o_wake(wk));
  psw_far_side psw_far_side_inst (.i_clk(clk), .o_sw_n(sw_n), .o_wake(wake));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // counts wake pulses as the design drives them, one per high cycle
  always @(posedge clk) begin
    if (wk === 1'b1) wakes <= wakes + 1;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic psw_rails_t rails_of(input psw_state_t s);
    case (s)
      PSW_OFF: return 5'h01;
      PSW_S3: return 5'h05;
      default: return 5'h1F;
    endcase
  endfunction
  function automatic psw_state_t btn_dest(input psw_tgt_t t, input logic cap);
    if (t == PSW_TGT_S5 || t == 2'h3) return PSW_OFF;
    if (t == PSW_TGT_S3 && cap) return PSW_S3;
    return PSW_S1;
  endfunction
  // state reached after a wake pattern: off takes rtc and lan, cpu-stopped modem and usb, suspend all four
  function automatic psw_state_t wake_dest(input psw_state_t s, input psw_wake_t w);
    if (s == PSW_OFF && (w.rtc || w.lan)) return PSW_WORK;
    if (s == PSW_S1 && (w.modem || w.usb)) return PSW_WORK;
    if (s == PSW_S3 && w != 4'h0) return PSW_WORK;
    return s;
  endfunction
  task automatic cmp(input string what, input logic [4:0] exp, input logic [4:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // waits a bounded time for a state, then checks it, its rails and the wake pulses seen so far
  task automatic reach(input psw_state_t s);
    #1;
    for (int i = 0; i < 80; i++) begin
      if (st === s) break;
      @(posedge clk);
      #1;
    end
    cmp("state", s, st);
    cmp("rails", rails_of(s), rails);
    if (prev inside {PSW_OFF, PSW_S1, PSW_S3} && s inside {PSW_BOOT, PSW_WORK}) exp_wakes++;
    prev = s;
    @(posedge clk);
    #1;
    cmp("wake pulses", 5'(exp_wakes), 5'(wakes));
  endtask
  task automatic os(input psw_tgt_t t);
    @(posedge clk);
    os_req <= '{1'b1, t};
    @(posedge clk);
    os_req <= '{1'b0, PSW_TGT_S5};
  endtask
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    psw_tgt_t t;
    logic c;
    psw_wake_t w;
    rst = 1'b1;
    strap = 1'b0;
    btn_tgt = PSW_TGT_S5;
    os_req = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reach(PSW_OFF);
    $display("test reset done");
    psw_far_side_inst.wake_pulse(4'h3);
    psw_far_side_inst.press(2);
    repeat (15) @(posedge clk);
    #1;
    cmp("state", PSW_OFF, st);
    $display("test ignored events done");
    psw_far_side_inst.press(8 + rnd() % 8);
    reach(PSW_BOOT);
    cmp("cold reset", 5'h01, {4'h0, cold_rst});
    reach(PSW_WORK);
    psw_far_side_inst.press(32 + rnd() % 16);
    reach(PSW_OFF);
    psw_far_side_inst.wake_pulse(4'h4);
    reach(PSW_BOOT);
    reach(PSW_WORK);
    $display("test switch and lan done");
    os(PSW_TGT_S1);
    reach(PSW_S1);
    cmp("cpu stop", 5'h01, {4'h0, cpu_stop});
    psw_far_side_inst.wake_pulse(4'h2);
    reach(PSW_WORK);
    os(PSW_TGT_S3);
    reach(PSW_S1);
    psw_far_side_inst.wake_pulse(4'h1);
    reach(PSW_WORK);
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    os(PSW_TGT_S3);
    reach(PSW_S3);
    psw_far_side_inst.wake_pulse(4'h8);
    reach(PSW_WORK);
    os(PSW_TGT_S3);
    reach(PSW_S3);
    psw_far_side_inst.press(10);
    reach(PSW_WORK);
    os(PSW_TGT_S1);
    reach(PSW_S1);
    psw_far_side_inst.press(40);
    reach(PSW_OFF);
    psw_far_side_inst.wake_pulse(4'h4);
    reach(PSW_WORK);
    os(PSW_TGT_S5);
    reach(PSW_OFF);
    $display("test software states done");
    for (int k = 0; k < 8; k++) begin
      psw_far_side_inst.wake_pulse(st === PSW_OFF ? 4'h8 : 4'h1);
      reach(PSW_WORK);
      t = psw_tgt_t'(rnd() % 3);
      c = 1'(rnd() % 2);
      btn_tgt <= t;
      strap <= c;
      repeat (4) @(posedge clk);
      psw_far_side_inst.press(8 + rnd() % 8);
      reach(btn_dest(t, c));
    end
    $display("test random short presses done");
    for (int k = 0; k < 10; k++) begin
      if (st !== PSW_WORK) begin
        psw_far_side_inst.wake_pulse(st === PSW_OFF ? 4'h4 : 4'h2);
        reach(PSW_WORK);
      end
      t = psw_tgt_t'(2'(rnd()));
      c = 1'(rnd());
      strap <= c;
      repeat (4) @(posedge clk);
      os(t);
      reach(btn_dest(t, c));
      w = psw_wake_t'(4'(rnd()));
      psw_far_side_inst.wake_pulse(w);
      reach(wake_dest(btn_dest(t, c), w));
    end
    $display("test random requests and wakes done");
    give_verdict();
  end
endmodule
`default_nettype wire
